/* File: rtl/ple_engine.sv */
// Notes on behaviour
// - word: cond1, operator, cond2, action; inputs 50-57
// - operator 0 is or
// - operator 2 is exclusive or
// - operator 3 true when both false
// - code 1 true, code 0 false
// - slots evaluated in ascending order
// - four variables, written 40+, read 100+
// - comparator a: quantity versus percent threshold
// - action 50 resets timer, 86 timeout
// - timer period in hundredths of seconds
// - restart before period means no timeout
// - action 19 raises drive fault
// - action 38 speed when true, torque false
// - 34 enables table select, 35 bit zero
// - jog enable, forward, reverse actions
// - output one optionally driven by engine
// - bits 35,36 choose one of four tables
`default_nettype none
module ple_engine
  import ple_pkg::*;
#(
  parameter int SCAN_CYCLES = SCAN_CYC,
  parameter int TICK_CYCLES = TICK_CYC
)(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // register port
  input  wire ple_req_t    req_in,
  output logic [31:0]      rdata_out,
  // drive side
  input  wire logic [7:0]  din_in,
  input  wire logic [7:0]  mon_pct_in,
  input  wire logic        dout1_fixed_in,
  output ple_act_t         act_out,
  output logic             dout1_out,
  output logic             irq_out
);

  // configuration storage
  logic [31:0]      slot_ff [SLOT_COUNT];
  logic [7:0]       ctrl_ff;
  logic [7:0]       cmp_src_ff;
  logic [7:0]       cmp_thr_ff;
  logic [15:0]      tmr_per_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic [31:0]      rdata_ff;

  // engine state
  ple_state_t       state_ff;
  logic [SLOT_IDX_W-1:0] idx_ff;
  logic [31:0]      scan_cnt_ff;
  logic [31:0]      tick_cnt_ff;
  logic [15:0]      tmr_cnt_ff;
  logic             tmr_rst_ff;
  logic             tmr_done_ff;
  logic [3:0]       var_ff;
  logic             tbl_en_ff;
  ple_act_t         work_ff;
  ple_act_t         act_ff;
  logic             dout1_ff;
  logic             cmp_ff;
  logic             fault_prev_ff;
  logic             tmo_prev_ff;

  // current statement fields
  logic [31:0] stmt;
  logic [7:0]  c1_code;
  logic [7:0]  op_code;
  logic [7:0]  c2_code;
  logic [7:0]  a_code;
  logic        c1;
  logic        c2;
  logic        res;
  logic        scan_tick;
  logic        pass_end;
  logic [16:0] tmr_cnt_inc;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_set;

  assign stmt    = slot_ff[idx_ff];
  assign c1_code = stmt[COND1_LSB +: 8];
  assign op_code = stmt[OPER_LSB +: 8];
  assign c2_code = stmt[COND2_LSB +: 8];
  assign a_code  = stmt[ACTION_LSB +: 8];
  // scan_tick starts a pass, pass_end marks its last slot
  assign scan_tick = (scan_cnt_ff == 32'(SCAN_CYCLES - 1));
  assign pass_end  = (state_ff == ST_EVAL) && (idx_ff == SLOT_IDX_W'(SLOT_COUNT - 1));
  assign tmr_cnt_inc = {1'b0, tmr_cnt_ff} + 17'h1; // one bit wider, no wrap at full scale

  // condition decode, variables see earlier slots this pass
  function automatic logic cond_val(input logic [7:0] code);
    logic v;
    v = 1'b0;
    if (code == COND_TRUE)
      v = 1'b1;
    else if (code >= COND_DIN_LO && code <= COND_DIN_HI)
      v = din_in[3'(code - COND_DIN_LO)];
    else if (code == COND_CMP_A)
      v = cmp_ff;
    else if (code == COND_TMR_A)
      v = tmr_done_ff;
    else if (code >= COND_VAR_LO && code <= COND_VAR_HI)
      v = var_ff[2'(code - COND_VAR_LO)];
    return v;
  endfunction

  // both conditions; a process so that input changes re-run the decode
  always_comb
  begin
    c1 = cond_val(c1_code);
    c2 = cond_val(c2_code);
  end

  // logic operator
  always_comb
  begin
    case (op_code)
      OP_OR:   res = c1 | c2;
      OP_AND:  res = c1 & c2;
      OP_XOR:  res = c1 ^ c2;
      OP_NOR:  res = ~(c1 | c2);
      default: res = 1'b0;
    endcase
  end

  // register writes
  // a slot written mid pass takes effect when that slot is next read
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < SLOT_COUNT; i++)
        slot_ff[i] <= 32'h0000_0000;
      ctrl_ff    <= 8'h00;
      cmp_src_ff <= 8'h00;
      cmp_thr_ff <= CMP_THR_RST;
      tmr_per_ff <= TMR_PER_RST;
      irq_en_ff  <= '0;
    end
    else if (ce_in && req_in.wr)
    begin
      if (req_in.addr < REG_CTRL)
        slot_ff[SLOT_IDX_W'(req_in.addr)] <= req_in.wdata;
      else if (req_in.addr == REG_CTRL)
        ctrl_ff <= req_in.wdata[7:0];
      else if (req_in.addr == REG_CMP_SRC)
        cmp_src_ff <= req_in.wdata[7:0];
      else if (req_in.addr == REG_CMP_THR)
        cmp_thr_ff <= req_in.wdata[7:0];
      else if (req_in.addr == REG_TMR_PER)
        tmr_per_ff <= req_in.wdata[15:0];
      else if (req_in.addr == REG_IRQ_EN)
        irq_en_ff <= req_in.wdata[IRQ_W-1:0];
    end
  end

  // register reads, one cycle later
  // unmapped and write-only addresses read back as zero
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_ff <= 32'h0000_0000;
    else if (ce_in)
    begin
      rdata_ff <= 32'h0000_0000;
      if (req_in.rd)
      begin
        if (req_in.addr < REG_CTRL)
          rdata_ff <= slot_ff[SLOT_IDX_W'(req_in.addr)];
        else if (req_in.addr == REG_CTRL)
          rdata_ff <= {24'h0, ctrl_ff};
        else if (req_in.addr == REG_CMP_SRC)
          rdata_ff <= {24'h0, cmp_src_ff};
        else if (req_in.addr == REG_CMP_THR)
          rdata_ff <= {24'h0, cmp_thr_ff};
        else if (req_in.addr == REG_TMR_PER)
          rdata_ff <= {16'h0, tmr_per_ff};
        else if (req_in.addr == REG_STATUS)
          rdata_ff <= {16'h0, tmr_cnt_ff[7:0], var_ff, tmr_done_ff, cmp_ff, act_ff.fault, tbl_en_ff};
        else if (req_in.addr == REG_IRQ_STAT)
          rdata_ff <= {29'h0, irq_stat_ff};
        else if (req_in.addr == REG_IRQ_EN)
          rdata_ff <= {29'h0, irq_en_ff};
      end
    end
  end

  // scan period counter
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      scan_cnt_ff <= 32'h0;
    else if (ce_in)
      scan_cnt_ff <= scan_tick ? 32'h0 : scan_cnt_ff + 32'h1;
  end

  // pass sequencer
  // a tick that lands mid pass is dropped; the scan must outlast a pass
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff <= ST_IDLE;
      idx_ff   <= '0;
    end
    else if (ce_in)
    begin
      case (state_ff)
        ST_IDLE:
          if (scan_tick && ctrl_ff[CTRL_RUN])
          begin
            state_ff <= ST_EVAL;
            idx_ff   <= '0;
          end
        ST_EVAL:
          if (pass_end)
            state_ff <= ST_DONE;
          else
            idx_ff <= idx_ff + 1'b1;
        ST_DONE:
          state_ff <= ST_IDLE;
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // per-slot action accumulation
  // variables persist across passes, actions restart from zero
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      work_ff    <= '0;
      var_ff     <= 4'h0;
      tmr_rst_ff <= 1'b0;
      tbl_en_ff  <= 1'b0;
    end
    else if (ce_in)
    begin
      if (state_ff == ST_IDLE && scan_tick)
      begin
        work_ff    <= '0;
        tmr_rst_ff <= 1'b0;
        tbl_en_ff  <= 1'b0;
      end
      else if (state_ff == ST_EVAL)
      begin
        if (a_code >= ACT_VAR_LO && a_code <= ACT_VAR_HI)
          var_ff[2'(a_code - ACT_VAR_LO)] <= res;
        case (a_code)
          ACT_FORWARD: work_ff.forward    <= res;
          ACT_REVERSE: work_ff.reverse    <= res;
          ACT_JOG_EN:  work_ff.jog_en     <= res;
          ACT_JOG_FWD: work_ff.jog_fwd    <= res;
          ACT_JOG_REV: work_ff.jog_rev    <= res;
          ACT_FAULT:   work_ff.fault      <= res;
          ACT_RESET:   work_ff.reset      <= res;
          ACT_PROC_EN: work_ff.proc_en    <= res;
          ACT_TRQ_SPD: work_ff.speed_mode <= res;
          ACT_TBL_EN:  tbl_en_ff          <= res;
          ACT_TBL_B0:  work_ff.table_sel[0] <= res;
          ACT_TBL_B1:  work_ff.table_sel[1] <= res;
          ACT_DOUT1:   work_ff.dout1      <= res;
          ACT_TMR_A:   tmr_rst_ff         <= tmr_rst_ff | res;
          default:     ;
        endcase
      end
    end
  end

  // publish actions at end of pass
  // table select falls back to table one unless enabled this pass
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      act_ff <= '0;
    else if (ce_in && state_ff == ST_DONE)
    begin
      act_ff <= work_ff;
      act_ff.table_sel <= tbl_en_ff ? work_ff.table_sel : 2'b00;
    end
  end

  // comparator a against percent threshold
  // strict compare: a reading equal to the threshold counts as below
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      cmp_ff <= 1'b0;
    else if (ce_in)
      cmp_ff <= (mon_pct_in > cmp_thr_ff);
  end

  // hundredth-second tick and timer a
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tick_cnt_ff <= 32'h0;
      tmr_cnt_ff  <= 16'h0;
      tmr_done_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      if (state_ff == ST_DONE && tmr_rst_ff)
      begin
        tick_cnt_ff <= 32'h0;
        tmr_cnt_ff  <= 16'h0;
        tmr_done_ff <= 1'b0;
      end
      else if (tick_cnt_ff == 32'(TICK_CYCLES - 1))
      begin
        tick_cnt_ff <= 32'h0;
        // expire on the tick that completes the period
        if (tmr_cnt_ff < tmr_per_ff)
          tmr_cnt_ff <= tmr_cnt_ff + 16'h1;
        if (tmr_cnt_inc >= {1'b0, tmr_per_ff})
          tmr_done_ff <= 1'b1;
      end
      else
        tick_cnt_ff <= tick_cnt_ff + 32'h1;
    end
  end

  // digital output one source
  // one cycle behind whichever source is selected
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      dout1_ff <= 1'b0;
    else if (ce_in)
      dout1_ff <= ctrl_ff[CTRL_DOUT1] ? act_ff.dout1 : dout1_fixed_in;
  end

  // interrupt events and software clear
  assign irq_clr = (req_in.wr && req_in.addr == REG_IRQ_CLR) ? req_in.wdata[IRQ_W-1:0] : '0;
  assign irq_set = {tmr_done_ff & ~tmo_prev_ff, act_ff.fault & ~fault_prev_ff, state_ff == ST_DONE};

  // sticky interrupt status, set beats clear
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      irq_stat_ff   <= '0;
      fault_prev_ff <= 1'b0;
      tmo_prev_ff   <= 1'b0;
    end
    else if (ce_in)
    begin
      fault_prev_ff <= act_ff.fault;
      tmo_prev_ff   <= tmr_done_ff;
      irq_stat_ff   <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  // interrupt output
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_out <= 1'b0;
    else if (ce_in)
      irq_out <= |(irq_stat_ff & irq_en_ff);
  end

  assign rdata_out = rdata_ff;
  assign act_out   = act_ff;
  assign dout1_out = dout1_ff;

endmodule // ple_engine
`default_nettype wire

/* File: rtl/ple_pkg.sv */
`default_nettype none
package ple_pkg;

  // statement table geometry
  localparam int          SLOT_COUNT   = 16;
  localparam int          SLOT_IDX_W   = 4;

  // statement word byte positions
  localparam int          COND1_LSB    = 24;
  localparam int          OPER_LSB     = 16;
  localparam int          COND2_LSB    = 8;
  localparam int          ACTION_LSB   = 0;

  // logic operator codes
  localparam logic [7:0]  OP_OR        = 8'h00;
  localparam logic [7:0]  OP_AND       = 8'h01;
  localparam logic [7:0]  OP_XOR       = 8'h02;
  localparam logic [7:0]  OP_NOR       = 8'h03;

  // condition codes
  localparam logic [7:0]  COND_FALSE   = 8'h00;
  localparam logic [7:0]  COND_TRUE    = 8'h01;
  localparam logic [7:0]  COND_DIN_LO  = 8'h32;  // input one, 50
  localparam logic [7:0]  COND_DIN_HI  = 8'h39;  // input eight, 57
  localparam logic [7:0]  COND_CMP_A   = 8'h4c;  // 76
  localparam logic [7:0]  COND_TMR_A   = 8'h56;  // 86
  localparam logic [7:0]  COND_VAR_LO  = 8'h64;  // variable a, 100
  localparam logic [7:0]  COND_VAR_HI  = 8'h67;  // variable d, 103

  // action codes
  localparam logic [7:0]  ACT_JOG_REV  = 8'h05;
  localparam logic [7:0]  ACT_JOG_FWD  = 8'h06;
  localparam logic [7:0]  ACT_JOG_EN   = 8'h12;  // 18
  localparam logic [7:0]  ACT_FAULT    = 8'h13;  // 19
  localparam logic [7:0]  ACT_FORWARD  = 8'h14;  // 20
  localparam logic [7:0]  ACT_REVERSE  = 8'h15;  // 21
  localparam logic [7:0]  ACT_RESET    = 8'h17;  // 23
  localparam logic [7:0]  ACT_PROC_EN  = 8'h1d;  // 29
  localparam logic [7:0]  ACT_TBL_EN   = 8'h22;  // 34
  localparam logic [7:0]  ACT_TBL_B0   = 8'h23;  // 35
  localparam logic [7:0]  ACT_TBL_B1   = 8'h24;  // 36
  localparam logic [7:0]  ACT_TRQ_SPD  = 8'h26;  // 38
  localparam logic [7:0]  ACT_VAR_LO   = 8'h28;  // variable a, 40
  localparam logic [7:0]  ACT_VAR_HI   = 8'h2b;  // variable d, 43
  localparam logic [7:0]  ACT_DOUT1    = 8'h2c;  // 44, output one
  localparam logic [7:0]  ACT_TMR_A    = 8'h32;  // 50

  // register map, word addresses
  localparam logic [7:0]  REG_SLOT_LO  = 8'h00;  // slots 0..15
  localparam logic [7:0]  REG_CTRL     = 8'h10;
  localparam logic [7:0]  REG_CMP_SRC  = 8'h11;
  localparam logic [7:0]  REG_CMP_THR  = 8'h12;
  localparam logic [7:0]  REG_TMR_PER  = 8'h13;
  localparam logic [7:0]  REG_STATUS   = 8'h14;
  localparam logic [7:0]  REG_IRQ_STAT = 8'h15;
  localparam logic [7:0]  REG_IRQ_EN   = 8'h16;
  localparam logic [7:0]  REG_IRQ_CLR  = 8'h17;

  // control bits
  localparam int          CTRL_RUN     = 0;
  localparam int          CTRL_DOUT1   = 1;

  // interrupt event bits
  localparam int          IRQ_W        = 3;
  localparam int          IRQ_PASS     = 0;
  localparam int          IRQ_FAULT    = 1;
  localparam int          IRQ_TIMEOUT  = 2;

  // timing: hundredth-second ticks at 40 MHz
  localparam int          CLK_HZ       = 40000000;
  localparam int          TICK_PER_S   = 100;
  localparam int          TICK_CYC     = CLK_HZ / TICK_PER_S;
  localparam int          SCAN_US      = 1000;
  localparam int          SCAN_CYC     = CLK_HZ / 1000000 * SCAN_US;

  // reset values
  localparam logic [15:0] TMR_PER_RST  = 16'h012c;  // 3.00 s
  localparam logic [7:0]  CMP_THR_RST  = 8'h14;     // 20 %

  // scan sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EVAL = 3'b010,
    ST_DONE = 3'b100
  } ple_state_t;

  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ple_req_t;

  // drive actions at end of pass
  typedef struct packed {
    logic       forward;
    logic       reverse;
    logic       jog_en;
    logic       jog_fwd;
    logic       jog_rev;
    logic       fault;
    logic       reset;
    logic       proc_en;
    logic       speed_mode;
    logic [1:0] table_sel;
    logic       dout1;
  } ple_act_t;

endpackage
`default_nettype wire

/* File: tb/ple_engine_sva.sv */
`default_nettype none
module ple_engine_chk
  import ple_pkg::*;
#(
  parameter int SCAN_CYCLES = SCAN_CYC
)(
  // watched ports
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  input wire ple_req_t    req_in,
  input wire logic [31:0] rdata_out,
  input wire ple_act_t    act_out,
  input wire logic        dout1_out,
  input wire logic        irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] gap_ff;
  ple_act_t    act_q_ff;

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // cycles since the last action change
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      gap_ff   <= SCAN_CYCLES;
      act_q_ff <= '0;
    end
    else if (ce_in)
    begin
      act_q_ff <= act_out;
      gap_ff   <= (act_out != act_q_ff) ? 32'h1 : gap_ff + 32'h1;
    end
  end

  chk_rdata_gated: assert property (
    rdata_out != 32'h0 |-> $past(req_in.rd) && $past(ce_in)) else $error("read data without a read");
  chk_unmapped_zero: assert property (
    req_in.rd && ce_in && req_in.addr > REG_IRQ_CLR |=> rdata_out == 32'h0) else $error("unmapped read not zero");
  chk_act_spacing: assert property (
    act_out != act_q_ff |-> gap_ff >= SCAN_CYCLES) else $error("actions changed twice in one scan");
  chk_irq_hold: assert property (
    irq_out && !req_in.wr && !$past(req_in.wr) |=> irq_out) else $error("interrupt dropped by itself");
  chk_irq_mask_drop: assert property (
    req_in.wr && ce_in && req_in.addr == REG_IRQ_EN && req_in.wdata[IRQ_W-1:0] == '0 |-> ##2 !irq_out)
    else $error("masked interrupt still high");
  chk_reset_clear: assert property (disable iff (1'b0)
    rst_in |-> act_out == '0 && !irq_out && !dout1_out && rdata_out == 32'h0) else $error("outputs live in reset");
  chk_quiet_start: assert property (
    $fell(rst_in) |-> (act_out == '0)[*8]) else $error("actions before first pass");
  chk_ce_freeze: assert property (
    !ce_in |=> $stable(act_out) && $stable(irq_out) && $stable(dout1_out)) else $error("state moved with enable low");
endmodule // ple_engine_chk

bind ple_engine ple_engine_chk #(.SCAN_CYCLES(SCAN_CYCLES)) u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .ce_in(ce_in), .req_in(req_in), .rdata_out(rdata_out), .act_out(act_out), .dout1_out(dout1_out),
  .irq_out(irq_out));
`default_nettype wire

/* File: tb/ple_drive_model.sv */
`default_nettype none
module ple_drive_model
  import ple_pkg::*;
(
  // clock
  input  wire logic      clk_in,
  // actions from the engine
  input  wire ple_act_t  act_in,
  // drive inputs
  output logic [7:0]     din_out,
  output logic [7:0]     mon_out,
  output logic           fixed_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic trip_ff = 1'b0;

  // inputs start low
  initial
  begin
    din_out   = 8'h00;
    mon_out   = 8'h00;
    fixed_out = 1'b0;
  end

  // new input levels just after an edge
  task set_in(input logic [7:0] d, input logic [7:0] m, input logic f);
    @(posedge clk_in);
    din_out   <= d;
    mon_out   <= m;
    fixed_out <= f;
  endtask

  // drive trips and stays tripped
  always @(posedge clk_in)
    if (act_in.fault)
      trip_ff <= 1'b1;
endmodule // ple_drive_model
`default_nettype wire

/* File: tb/ple_engine_tb.sv */
`default_nettype none
module ple_engine_tb;
  import ple_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SCAN = 20;
  localparam int TICK = 50;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b0;
  logic        ce_in  = 1'b1;
  ple_req_t    req    = '0;
  logic [31:0] rdata;
  logic [7:0]  din, mon;
  logic        fixed, dout1, irq;
  ple_act_t    act;
  logic [31:0] slots [16];
  logic [7:0]  ops [4] = '{OP_OR, OP_AND, OP_XOR, OP_NOR};
  int          fail_count = 0;
  int          tests_run = 0;
  int          cyc = 0;

  ple_engine #(.SCAN_CYCLES(SCAN), .TICK_CYCLES(TICK)) uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .req_in(req), .rdata_out(rdata), .din_in(din), .mon_pct_in(mon), .dout1_fixed_in(fixed),
    .act_out(act), .dout1_out(dout1), .irq_out(irq));
  ple_drive_model drv (.clk_in(clk_in), .act_in(act), .din_out(din), .mon_out(mon), .fixed_out(fixed));

  // clock
  always #12.5 clk_in = ~clk_in;

  // hang guard
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      fail_count++;
      finish_test;
    end
  end

  function automatic logic [31:0] w(input logic [7:0] c1, op, c2, a);
    return {c1, op, c2, a};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk_in);
    req.wr    <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clk_in);
    req.rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task load;
    for (int i = 0; i < 16; i++)
      wr(REG_SLOT_LO + 8'(i), slots[i]);
  endtask

  task wait_pass;
    repeat (2 * SCAN + 4) @(posedge clk_in);
    #1;
  endtask

  task t_reset;
    logic [31:0] d;
    rd(REG_CMP_THR, d);
    chk(d, {24'h0, CMP_THR_RST}, "threshold reset");
    rd(REG_TMR_PER, d);
    chk(d, {16'h0, TMR_PER_RST}, "period reset");
    rd(8'h20, d);
    chk(d, 32'h0, "unmapped read");
    $display("test reset done");
  endtask

  task t_ops;
    logic e;
    for (int o = 0; o < 4; o++)
    begin
      slots = '{default: 32'h0};
      slots[0] = w(COND_DIN_LO, ops[o], COND_DIN_LO + 8'h01, ACT_FORWARD);
      slots[1] = w(COND_TRUE, OP_OR, COND_FALSE, ACT_REVERSE);
      slots[2] = w(8'h3a, OP_OR, COND_FALSE, ACT_RESET);
      slots[3] = w(COND_TRUE, 8'h04, COND_TRUE, ACT_PROC_EN);
      load;
      for (int j = 0; j < 4; j++)
      begin
        drv.set_in({6'h0, j[1], j[0]}, 8'h00, 1'b0);
        wait_pass;
        e = (o == 0) ? j[0] | j[1] : (o == 1) ? j[0] & j[1] : (o == 2) ? j[0] ^ j[1] : !(j[0] | j[1]);
        chk({31'h0, act.forward}, {31'h0, e}, "operator");
      end
    end
    chk({31'h0, act.reverse}, 32'h1, "constant true");
    chk({31'h0, act.reset}, 32'h0, "unknown condition");
    chk({31'h0, act.proc_en}, 32'h0, "unknown operator");
    $display("test ops done");
  endtask

  task t_cmp;
    slots = '{default: 32'h0};
    slots[0] = w(COND_CMP_A, OP_OR, COND_FALSE, ACT_VAR_LO);
    slots[1] = w(COND_VAR_LO, OP_OR, COND_FALSE, ACT_TRQ_SPD);
    slots[2] = w(COND_DIN_LO + 8'h03, OP_XOR, COND_VAR_LO, ACT_PROC_EN);
    load;
    for (int k = 0; k < 4; k++)
    begin
      drv.set_in({4'h0, k[1], 3'h0}, k[0] ? 8'h15 : 8'h14, 1'b0);
      wait_pass;
      chk({31'h0, act.speed_mode}, {31'h0, k[0]}, "speed select");
      chk({31'h0, act.proc_en}, {31'h0, k[0] ^ k[1]}, "loop enable");
    end
    $display("test comparator done");
  endtask

  task t_table;
    slots = '{default: 32'h0};
    slots[0] = w(COND_TRUE, OP_OR, COND_FALSE, ACT_TBL_EN);
    slots[1] = w(COND_DIN_LO, OP_OR, COND_FALSE, ACT_TBL_B0);
    slots[2] = w(COND_DIN_LO + 8'h01, OP_OR, COND_FALSE, ACT_TBL_B1);
    slots[3] = w(COND_DIN_LO + 8'h02, OP_OR, COND_DIN_LO + 8'h03, ACT_JOG_EN);
    slots[4] = w(COND_DIN_LO + 8'h02, OP_OR, COND_FALSE, ACT_JOG_FWD);
    slots[5] = w(COND_DIN_LO + 8'h03, OP_OR, COND_FALSE, ACT_JOG_REV);
    slots[6] = w(COND_DIN_LO + 8'h04, OP_OR, COND_FALSE, ACT_DOUT1);
    wr(REG_CTRL, 32'h3);
    load;
    for (int k = 0; k < 4; k++)
    begin
      drv.set_in({3'h0, k[0], k[1], k[0], k[1], k[0]}, 8'h00, 1'b0);
      wait_pass;
      chk({30'h0, act.table_sel}, {30'h0, k[1], k[0]}, "table select");
      chk({29'h0, act.jog_en, act.jog_fwd, act.jog_rev}, {29'h0, k[0] | k[1], k[0], k[1]}, "jog");
      chk({31'h0, dout1}, {31'h0, k[0]}, "engine output");
    end
    @(posedge clk_in);
    ce_in <= 1'b0;
    drv.set_in(8'h00, 8'h00, 1'b0);
    repeat (2 * SCAN) @(posedge clk_in);
    #1 chk({30'h0, act.table_sel}, 32'h3, "frozen");
    @(posedge clk_in);
    ce_in <= 1'b1;
    wr(REG_CTRL, 32'h1);
    drv.set_in(8'h00, 8'h00, 1'b1);
    repeat (4) @(posedge clk_in);
    #1 chk({31'h0, dout1}, 32'h1, "fixed source");
    $display("test table done");
  endtask

  task t_timer;
    logic [31:0] d;
    slots = '{default: 32'h0};
    slots[0] = w(COND_DIN_HI, OP_OR, COND_FALSE, ACT_TMR_A);
    slots[1] = w(COND_TMR_A, OP_OR, COND_FALSE, ACT_FAULT);
    drv.set_in(8'h80, 8'h00, 1'b0);
    load;
    wait_pass;
    // short period only once restarts run, so nothing trips early
    wr(REG_TMR_PER, 32'h4);
    rd(REG_TMR_PER, d);
    chk(d, 32'h4, "period");
    wr(REG_IRQ_EN, 32'h1 << IRQ_FAULT);
    wr(REG_IRQ_CLR, 32'h7);
    drv.set_in(8'h00, 8'h00, 1'b0);
    repeat (40) @(posedge clk_in);
    drv.set_in(8'h80, 8'h00, 1'b0);
    repeat (6 * TICK) @(posedge clk_in);
    #1 chk({31'h0, act.fault}, 32'h0, "short dropout");
    chk({31'h0, drv.trip_ff}, 32'h0, "no early trip");
    drv.set_in(8'h00, 8'h00, 1'b0);
    repeat (8 * TICK) @(posedge clk_in);
    #1 chk({31'h0, act.fault}, 32'h1, "timeout fault");
    chk({31'h0, drv.trip_ff}, 32'h1, "drive tripped");
    chk({31'h0, irq}, 32'h1, "fault interrupt");
    rd(REG_STATUS, d);
    chk({30'h0, d[3], d[1]}, 32'h3, "status timer and fault");
    wr(REG_IRQ_EN, 32'h0);
    repeat (3) @(posedge clk_in);
    #1 chk({31'h0, irq}, 32'h0, "masked");
    rd(REG_IRQ_STAT, d);
    chk({31'h0, d[IRQ_FAULT]}, 32'h1, "sticky status");
    chk(d, 32'h7, "all events latched");
    wr(REG_IRQ_CLR, 32'h1 << IRQ_FAULT);
    rd(REG_IRQ_STAT, d);
    chk({31'h0, d[IRQ_FAULT]}, 32'h0, "cleared");
    $display("test timer done");
  endtask

  task finish_test;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial
  begin
    rst_in <= 1'b1; // a real rising edge, so every flop resets at once
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset;
    wr(REG_CTRL, 32'h1);
    t_ops;
    t_cmp;
    t_table;
    t_timer;
    finish_test;
  end
endmodule // ple_engine_tb
`default_nettype wire
